// File: core/gsr_errq.sv
// Status reporting package and the error queue that it feeds.
// Assumes one instrument clock and a synchronous, active-high reset shared by all users.

`timescale 1ns/1ps

package gsr_pkg;
    // Event status bit positions.
    localparam int ESR_OPC_BIT  = 0;
    localparam int ESR_RSV_BIT  = 1;
    localparam int ESR_QRY_BIT  = 2;
    localparam int ESR_DDE_BIT  = 3;
    localparam int ESR_EXE_BIT  = 4;
    localparam int ESR_CME_BIT  = 5;
    localparam int ESR_URQ_BIT  = 6;
    localparam int ESR_PON_BIT  = 7;
    // Status byte bit positions.
    localparam int STB_EAV_BIT  = 2;
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;
    localparam int STB_MSS_BIT  = 6;
    localparam int STB_OPER_BIT = 7;
    // Status byte bits that can raise a service request.
    localparam logic [7:0] SRQ_BITS    = 8'hBC;
    // Reset values: the power-on event is already recorded when reset releases.
    localparam logic [7:0] ESR_RST     = 8'h80;
    localparam logic [7:0] ESE_RST     = 8'h00;
    localparam logic [7:0] SRE_RST     = 8'h00;
    localparam logic [7:0] PPE_RST     = 8'h00;
    localparam logic [2:0] PPLINE_RST  = 3'h0;
    localparam logic [15:0] NO_ERROR   = 16'h0000;
    localparam int ERRQ_DEPTH          = 16;
    localparam int CODE_W              = 16;

    typedef enum logic [3:0] {
        GSR_CMD_WR_PRE = 4'h0,
        GSR_CMD_RD_PRE = 4'h1,
        GSR_CMD_WR_ESE = 4'h2,
        GSR_CMD_RD_ESE = 4'h3,
        GSR_CMD_RD_ESR = 4'h4,
        GSR_CMD_WR_SRE = 4'h5,
        GSR_CMD_RD_SRE = 4'h6,
        GSR_CMD_RD_STB = 4'h7,
        GSR_CMD_RD_IST = 4'h8,
        GSR_CMD_RD_ERR = 4'h9,
        GSR_CMD_CLS    = 4'hA
    } gsr_cmd_t;
endpackage

module gsr_errq #(
    parameter int DEPTH = gsr_pkg::ERRQ_DEPTH,
    parameter int W     = gsr_pkg::CODE_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Write side
    input  wire logic         push,
    input  wire logic [W-1:0] push_code,
    input  wire logic         flush,
    // Read side
    input  wire logic         pop,
    output logic      [W-1:0] head_code,
    output logic              empty,
    output logic              full
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0]   count_reg;
    logic          do_push;
    logic          do_pop;

    // A full queue drops new entries so that the oldest causes stay readable.
    assign full      = (count_reg == (AW+1)'(DEPTH));
    assign empty     = (count_reg == '0);
    assign do_push   = push && (!full || flush);
    assign do_pop    = pop && !empty;
    assign head_code = mem[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[flush ? '0 : wr_ptr_reg] <= push_code;
        end
    end

    // An error arriving in the flush cycle is kept as the only entry after the flush, just as its event bit is kept.
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (flush) begin
            wr_ptr_reg <= do_push ? AW'(1) : '0;
            rd_ptr_reg <= '0;
            count_reg  <= (AW+1)'(do_push);
        end else begin
            if (do_push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // gsr_errq

// File: core/gsr_status.sv
// Status reporting core: event status and its enable, status byte, service request,
// individual status flag, serial and parallel poll answers, and the error queue.
// Assumes the command parser and bus interface run on clk; only the local key is a pin.
//
// Operation
// - IST is OR of status byte bits ANDed with PPE, bit 6 included.
// - PPE mask is written and read back by commands.
// - Event bit 0 sets when operation-complete arrives after all earlier commands.
// - Event bit 2 sets on a query error.
// - Event bit 3 sets on device error, and its code enters the error queue.
// - Event bit 4 sets on execution error, and its code enters the error queue.
// - Event bit 5 sets on command error, and its code enters the error queue.
// - Event bit 6 sets when the local key returns the unit to manual control.
// - Event bit 7 sets at power up.
// - Event register readable; event enable mask written and read back.
// - Service request when status bits 2,3,4,5 or 7 are set and enabled.
// - Serial poll answers with the status byte, same as the status query.
// - Parallel poll drives the assigned line with IST, optionally inverted.
// - Parallel poll line and sense are configured and stored before use.
// - IST query returns the individual status flag without a poll.
// - Every status query answers one number equal to the register bits.
// - Each cycle with a device, execution or command error adds one entry while not full; error query pops one, or returns zero.
// - Status bit 5 is set while any enabled event bit is set.
// - Status bit 6 summarises enabled status bits; enable bit 6 ignored.
// - Reading the event register returns it and then clears it.
// - Status bit 2 is set while the error queue is not empty.

`timescale 1ns/1ps

module gsr_status (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Command port from the parser
    input  wire logic                          cmd_valid,
    input  wire gsr_pkg::gsr_cmd_t             cmd_code,
    input  wire logic [7:0]                    cmd_data,
    // Query answer
    output logic                               rsp_valid,
    output logic [gsr_pkg::CODE_W-1:0]         rsp_data,
    // Events from the instrument
    input  wire logic                          opc_done,
    input  wire logic                          query_err,
    input  wire logic                          dev_err,
    input  wire logic [gsr_pkg::CODE_W-1:0]    dev_err_code,
    input  wire logic                          exec_err,
    input  wire logic [gsr_pkg::CODE_W-1:0]    exec_err_code,
    input  wire logic                          syntax_err,
    input  wire logic [gsr_pkg::CODE_W-1:0]    syntax_err_code,
    input  wire logic                          msg_avail,
    input  wire logic                          local_key,
    // Serial poll
    input  wire logic                          spoll_req,
    output logic [7:0]                         spoll_byte,
    // Parallel poll configuration and response
    input  wire logic                          pp_cfg_valid,
    input  wire logic                          pp_cfg_enable,
    input  wire logic [2:0]                    pp_cfg_line,
    input  wire logic                          pp_cfg_invert,
    input  wire logic                          pp_active,
    output logic [7:0]                         pp_dio_o,
    output logic [7:0]                         pp_dio_oe,
    // Summary outputs
    output logic                               srq,
    output logic                               ist
);
    import gsr_pkg::*;

    logic [7:0]        esr_reg;
    logic [7:0]        esr_set;
    logic [7:0]        ese_reg;
    logic [7:0]        sre_reg;
    logic [7:0]        ppe_reg;
    logic              pp_en_reg;
    logic [2:0]        pp_line_reg;
    logic              pp_inv_reg;
    logic [7:0]        stb;
    logic              esb;
    logic              mss;
    logic              esr_rd;
    logic              err_rd;
    logic              cls;
    logic              eq_empty;
    logic              eq_full;
    logic              eq_push;
    logic [CODE_W-1:0] eq_code;
    logic [CODE_W-1:0] eq_head;
    logic [2:0]        key_sync_reg;
    logic              key_reg;
    logic              key_rise;

    ////////////////////////////////////////////////////////////////////////////////
    // Local key pin: three flops, a change is accepted once the last two agree.

    always_ff @(posedge clk) begin
        if (srst) begin
            key_sync_reg <= 3'h0;
            key_reg      <= 1'b0;
        end else begin
            key_sync_reg <= {key_sync_reg[1:0], local_key};
            if (key_sync_reg[1] == key_sync_reg[2]) begin
                key_reg <= key_sync_reg[2];
            end
        end
    end

    assign key_rise = (key_sync_reg[1] == key_sync_reg[2]) && key_sync_reg[2] && !key_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Event status register.

    assign esr_rd = cmd_valid && (cmd_code == GSR_CMD_RD_ESR);
    assign err_rd = cmd_valid && (cmd_code == GSR_CMD_RD_ERR);
    assign cls    = cmd_valid && (cmd_code == GSR_CMD_CLS);

    always_comb begin
        esr_set              = 8'h00;
        esr_set[ESR_OPC_BIT] = opc_done;
        esr_set[ESR_QRY_BIT] = query_err;
        esr_set[ESR_DDE_BIT] = dev_err;
        esr_set[ESR_EXE_BIT] = exec_err;
        esr_set[ESR_CME_BIT] = syntax_err;
        esr_set[ESR_URQ_BIT] = key_rise;
        esr_set[ESR_RSV_BIT] = 1'b0;
    end

    // An event landing in the read or clear cycle survives, so no event is ever lost.
    always_ff @(posedge clk) begin
        if (srst) begin
            esr_reg <= ESR_RST;
        end else if (esr_rd || cls) begin
            esr_reg <= esr_set;
        end else begin
            esr_reg <= esr_reg | esr_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable masks and parallel poll configuration.

    always_ff @(posedge clk) begin
        if (srst) begin
            ese_reg <= ESE_RST;
            sre_reg <= SRE_RST;
            ppe_reg <= PPE_RST;
        end else if (cmd_valid) begin
            if (cmd_code == GSR_CMD_WR_ESE) begin
                ese_reg <= cmd_data;
            end
            if (cmd_code == GSR_CMD_WR_SRE) begin
                sre_reg <= cmd_data;
            end
            if (cmd_code == GSR_CMD_WR_PRE) begin
                ppe_reg <= cmd_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pp_en_reg   <= 1'b0;
            pp_line_reg <= PPLINE_RST;
            pp_inv_reg  <= 1'b0;
        end else if (pp_cfg_valid) begin
            pp_en_reg   <= pp_cfg_enable;
            pp_line_reg <= pp_cfg_line;
            pp_inv_reg  <= pp_cfg_invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status byte, service request and individual status.

    assign esb = |(esr_reg & ese_reg);

    // The summary is taken before bit 6 is filled in, so it never feeds on itself.
    always_comb begin
        stb               = 8'h00;
        stb[STB_EAV_BIT]  = !eq_empty;
        stb[STB_QUES_BIT] = 1'b0;
        stb[STB_MAV_BIT]  = msg_avail;
        stb[STB_ESB_BIT]  = esb;
        stb[STB_OPER_BIT] = 1'b0;
        mss               = |(stb & sre_reg & SRQ_BITS);
        stb[STB_MSS_BIT]  = mss;
    end

    assign srq = mss;
    assign ist = |(stb & ppe_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Error queue: one entry per cycle; when several coincide only one code enters, command over execution over device.

    assign eq_push = syntax_err || exec_err || dev_err;
    assign eq_code = syntax_err ? syntax_err_code : (exec_err ? exec_err_code : dev_err_code);

    gsr_errq #(
        .DEPTH (ERRQ_DEPTH),
        .W     (CODE_W)
    ) u_errq (
        .clk       (clk),
        .srst      (srst),
        .push      (eq_push),
        .push_code (eq_code),
        .flush     (cls),
        .pop       (err_rd),
        .head_code (eq_head),
        .empty     (eq_empty),
        .full      (eq_full)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Query answers, one cycle after the command.

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= NO_ERROR;
        end else begin
            rsp_valid <= cmd_valid && (cmd_code inside {GSR_CMD_RD_PRE, GSR_CMD_RD_ESE, GSR_CMD_RD_ESR,
                                                        GSR_CMD_RD_SRE, GSR_CMD_RD_STB, GSR_CMD_RD_IST,
                                                        GSR_CMD_RD_ERR});
            if (cmd_valid) begin
                unique case (cmd_code)
                    GSR_CMD_RD_PRE: rsp_data <= {8'h00, ppe_reg};
                    GSR_CMD_RD_ESE: rsp_data <= {8'h00, ese_reg};
                    GSR_CMD_RD_ESR: rsp_data <= {8'h00, esr_reg};
                    GSR_CMD_RD_SRE: rsp_data <= {8'h00, sre_reg};
                    GSR_CMD_RD_STB: rsp_data <= {8'h00, stb};
                    GSR_CMD_RD_IST: rsp_data <= {15'h0000, ist};
                    GSR_CMD_RD_ERR: rsp_data <= eq_empty ? NO_ERROR : eq_head;
                    default:        rsp_data <= rsp_data;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial and parallel poll answers.

    always_ff @(posedge clk) begin
        if (srst) begin
            spoll_byte <= 8'h00;
        end else if (spoll_req) begin
            spoll_byte <= stb;
        end
    end

    // Each line is driven only while a poll is active and this unit owns that line.
    for (genvar i = 0; i < 8; i++) begin : g_pp_line
        always_ff @(posedge clk) begin
            if (srst) begin
                pp_dio_o[i]  <= 1'b0;
                pp_dio_oe[i] <= 1'b0;
            end else begin
                pp_dio_o[i]  <= ist ^ pp_inv_reg;
                pp_dio_oe[i] <= pp_active && pp_en_reg && (pp_line_reg == 3'(i));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_ist_or;
        @(posedge clk) disable iff (srst) ist == |({1'b0, mss, esb, msg_avail, 1'b0, !eq_empty, 2'b00} & ppe_reg);
    endproperty
    a_ist_or: assert property (p_ist_or) else $error("IST does not match status byte and PPE");

    property p_ppe_rb;
        @(posedge clk) disable iff (srst)
            (cmd_valid && cmd_code == GSR_CMD_WR_PRE) ##1 !(cmd_valid && cmd_code == GSR_CMD_WR_PRE)
            ##1 (cmd_valid && cmd_code == GSR_CMD_RD_PRE)
            |=> rsp_valid && rsp_data[7:0] == $past(cmd_data, 3);
    endproperty
    a_ppe_rb: assert property (p_ppe_rb) else $error("PPE read back differs from write");

    property p_opc;
        @(posedge clk) disable iff (srst) opc_done |=> esr_reg[ESR_OPC_BIT];
    endproperty
    a_opc: assert property (p_opc) else $error("Operation complete bit not set");

    property p_syntax_q;
        @(posedge clk) disable iff (srst) syntax_err && !eq_full |=> !eq_empty && esr_reg[ESR_CME_BIT];
    endproperty
    a_syntax_q: assert property (p_syntax_q) else $error("Command error not recorded");

    property p_esr_read;
        @(posedge clk) disable iff (srst)
            esr_rd && esr_set == 8'h00 |=> esr_reg == 8'h00 && rsp_valid && rsp_data[7:0] == $past(esr_reg);
    endproperty
    a_esr_read: assert property (p_esr_read) else $error("Event register read did not return and clear");

    property p_srq;
        @(posedge clk) disable iff (srst) srq == |({1'b0, 1'b0, esb, msg_avail, 1'b0, !eq_empty, 2'b00} & sre_reg);
    endproperty
    a_srq: assert property (p_srq) else $error("Service request does not match enabled status");

    property p_err_empty;
        @(posedge clk) disable iff (srst) err_rd && eq_empty |=> rsp_valid && rsp_data == NO_ERROR;
    endproperty
    a_err_empty: assert property (p_err_empty) else $error("Empty error queue did not answer zero");

    property p_pp_drive;
        @(posedge clk) disable iff (srst)
            pp_active && pp_en_reg |=> pp_dio_oe[$past(pp_line_reg)] && $onehot(pp_dio_oe)
                                       && pp_dio_o[$past(pp_line_reg)] == ($past(ist) ^ $past(pp_inv_reg));
    endproperty
    a_pp_drive: assert property (p_pp_drive) else $error("Parallel poll line not driven correctly");

    property p_spoll;
        @(posedge clk) disable iff (srst) spoll_req |=> spoll_byte == $past(stb);
    endproperty
    a_spoll: assert property (p_spoll) else $error("Serial poll byte differs from status byte");

    property p_zero_bits;
        @(posedge clk) disable iff (srst) !esr_reg[ESR_RSV_BIT] && !stb[STB_QUES_BIT] && !stb[STB_OPER_BIT];
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("Unused status bit set");
endmodule // gsr_status

// File: tb/gsr_ctl_model.sv
// Bus controller model: issues commands, configures and runs polls, resolves the data lines.
// Assumes the bench calls its tasks one at a time; every input moves on the falling edge.
`timescale 1ns/1ps
module gsr_ctl_model (
    // Clock
    input  wire logic                  clk,
    // Command port
    output gsr_pkg::gsr_cmd_t          cmd_code,
    output logic                       cmd_valid,
    output logic [7:0]                 cmd_data,
    input  wire logic                  rsp_valid,
    input  wire logic [15:0]           rsp_data,
    // Polls
    output logic                       spoll_req,
    input  wire logic [7:0]            spoll_byte,
    output logic                       pp_cfg_valid,
    output logic                       pp_cfg_enable,
    output logic [2:0]                 pp_cfg_line,
    output logic                       pp_cfg_invert,
    output logic                       pp_active,
    input  wire logic [7:0]            pp_dio_o,
    input  wire logic [7:0]            pp_dio_oe,
    output logic [7:0]                 dio_bus
);
    import gsr_pkg::*;
    initial begin
        {cmd_valid, cmd_data, spoll_req, pp_cfg_valid, pp_active} = '0;
        {pp_cfg_enable, pp_cfg_line, pp_cfg_invert} = '0;
        cmd_code = GSR_CMD_RD_STB;
    end
    // Undriven lines float to the pull-up level.
    assign dio_bus = (pp_dio_oe & pp_dio_o) | ~pp_dio_oe;
    // Stale write data is inverted so a late sample cannot match by chance.
    task automatic send(input gsr_cmd_t c, input logic [7:0] d, output logic got, output logic [15:0] r);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_data = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_data = ~d;
        got = rsp_valid;
        r = rsp_data;
    endtask
    task automatic cfg_pp(input logic [2:0] ln, input logic inv);
        @(negedge clk);
        {pp_cfg_valid, pp_cfg_enable, pp_cfg_line, pp_cfg_invert} = {2'b11, ln, inv};
        @(negedge clk);
        pp_cfg_valid = 1'b0;
    endtask
    task automatic ppoll(output logic [7:0] oe, output logic [7:0] lv);
        @(negedge clk);
        pp_active = 1'b1;
        @(negedge clk);
        oe = pp_dio_oe;
        lv = dio_bus;
        pp_active = 1'b0;
    endtask
    task automatic spoll(output logic [7:0] b);
        @(negedge clk);
        spoll_req = 1'b1;
        @(negedge clk);
        spoll_req = 1'b0;
        b = spoll_byte;
    endtask
endmodule // gsr_ctl_model

// File: tb/gsr_status_tb_top.sv
// Self-checking bench for gsr_status: seeded random traffic plus directed corner cases.
// Assumes gsr_ctl_model drives the command and poll ports in the controller's place.
`timescale 1ns/1ps
module gsr_status_tb_top;
    import gsr_pkg::*;
    localparam int LIMIT = 20000;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic [4:0]        evp = 5'h00;
    logic [15:0]       err_code = 16'h0000;
    logic              msg_avail = 1'b0;
    logic              local_key = 1'b0;
    gsr_cmd_t          cmd_code;
    logic              cmd_valid, spoll_req, pp_cfg_valid, pp_cfg_enable, pp_cfg_invert, pp_active;
    logic              rsp_valid, srq, ist;
    logic [2:0]        pp_cfg_line;
    logic [7:0]        cmd_data, spoll_byte, pp_dio_o, pp_dio_oe, dio_bus, d, oe, lv;
    logic [15:0]       rsp_data, lfsr = 16'h005B, r;
    logic [7:0]        m_esr, m_msk [3];
    logic [15:0]       m_q [$];
    int                n_mismatch = 0, comparisons = 0, cyc = 0, i, k;
    int                eb [5] = '{0, 2, 3, 4, 5};
    gsr_cmd_t          wcmd [3] = '{GSR_CMD_WR_PRE, GSR_CMD_WR_ESE, GSR_CMD_WR_SRE};
    gsr_cmd_t          rcmd [3] = '{GSR_CMD_RD_PRE, GSR_CMD_RD_ESE, GSR_CMD_RD_SRE};

    gsr_status dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .opc_done(evp[0]),
        .query_err(evp[1]), .dev_err(evp[2]), .dev_err_code(err_code), .exec_err(evp[3]),
        .exec_err_code(err_code), .syntax_err(evp[4]), .syntax_err_code(err_code),
        .msg_avail(msg_avail), .local_key(local_key), .spoll_req(spoll_req), .spoll_byte(spoll_byte),
        .pp_cfg_valid(pp_cfg_valid), .pp_cfg_enable(pp_cfg_enable), .pp_cfg_line(pp_cfg_line),
        .pp_cfg_invert(pp_cfg_invert), .pp_active(pp_active), .pp_dio_o(pp_dio_o),
        .pp_dio_oe(pp_dio_oe), .srq(srq), .ist(ist));
    gsr_ctl_model u_ctl (.clk(clk), .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spoll_req(spoll_req), .spoll_byte(spoll_byte),
        .pp_cfg_valid(pp_cfg_valid), .pp_cfg_enable(pp_cfg_enable), .pp_cfg_line(pp_cfg_line),
        .pp_cfg_invert(pp_cfg_invert), .pp_active(pp_active), .pp_dio_o(pp_dio_o),
        .pp_dio_oe(pp_dio_oe), .dio_bus(dio_bus));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [7:0] stb_f();
        logic [7:0] s;
        s = 8'h00;
        s[STB_EAV_BIT] = (m_q.size() != 0);
        s[STB_MAV_BIT] = msg_avail;
        s[STB_ESB_BIT] = |(m_esr & m_msk[1]);
        s[STB_MSS_BIT] = |(s & m_msk[2] & 8'hBF);
        return s;
    endfunction
    function automatic logic ist_f();
        return |(stb_f() & m_msk[0]);
    endfunction
    // Codes sit inside each error class's documented range.
    function automatic logic [15:0] ecode(int k, logic [15:0] r);
        int v;
        v = -100 - int'(r) % 100;
        if (k == 3) v = -200 - int'(r) % 100;
        if (k == 2) v = r[0] ? int'(r[7:1]) + 1 : -300 - int'(r) % 100;
        return v[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input gsr_cmd_t c, input logic [15:0] exp);
        logic got;
        logic [15:0] q;
        u_ctl.send(c, 8'h00, got, q);
        chk({15'h0000, got}, 16'h0001);
        chk(q, exp);
    endtask
    task automatic wr(input gsr_cmd_t c, input logic [7:0] v);
        logic got;
        logic [15:0] q;
        u_ctl.send(c, v, got, q);
        chk({15'h0000, got}, 16'h0000);
    endtask
    task automatic rd_err();
        rd(GSR_CMD_RD_ERR, m_q.size() != 0 ? m_q.pop_front() : NO_ERROR);
    endtask
    task automatic ev(input int k, input logic [15:0] c);
        @(negedge clk);
        evp = 5'h01 << k;
        err_code = c;
        @(negedge clk);
        evp = 5'h00;
        err_code = ~c;
        m_esr[eb[k]] = 1'b1;
        if (k >= 2 && m_q.size() < ERRQ_DEPTH) m_q.push_back(c);
    endtask
    task automatic sum_chk();
        logic [7:0] s;
        s = stb_f();
        chk({15'h0000, srq}, {15'h0000, s[STB_MSS_BIT]});
        chk({15'h0000, ist}, {15'h0000, ist_f()});
    endtask
    task automatic close_out();
        $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        m_esr = ESR_RST;
        m_msk = '{PPE_RST, ESE_RST, SRE_RST};
        repeat (10) @(negedge clk);
        srst = 1'b0;
        sum_chk();
        rd(GSR_CMD_RD_ESR, 16'h0080);
        m_esr = 8'h00;
        rd(GSR_CMD_RD_ESR, 16'h0000);
        rd_err();
        wr(gsr_cmd_t'(4'hB), 8'hFF);
        // Overflow: entries beyond the depth are dropped, the rest come back in order.
        for (i = 0; i < ERRQ_DEPTH + 2; i++) ev(4, ecode(4, rnd()));
        sum_chk();
        for (i = 0; i <= ERRQ_DEPTH; i++) rd_err();
        ev(2, ecode(2, rnd()));
        wr(GSR_CMD_CLS, 8'h00);
        m_esr = 8'h00;
        m_q.delete();
        rd(GSR_CMD_RD_ESR, 16'h0000);
        rd_err();
        @(negedge clk);
        local_key = 1'b1;
        repeat (8) @(negedge clk);
        m_esr[ESR_URQ_BIT] = 1'b1;
        local_key = 1'b0;
        repeat (8) @(negedge clk);
        rd(GSR_CMD_RD_ESR, {8'h00, m_esr});
        m_esr = 8'h00;
        for (i = 0; i < 300; i++) begin
            r = rnd();
            k = int'(r[5:3]) % 5;
            case (r[2:0])
                3'h0, 3'h1: ev(k, ecode(k, r));
                3'h2: begin
                    k = int'(r[5:3]) % 3;
                    wr(wcmd[k], r[15:8]);
                    m_msk[k] = r[15:8];
                    rd(rcmd[k], {8'h00, m_msk[k]});
                end
                3'h3: begin
                    rd(GSR_CMD_RD_ESR, {8'h00, m_esr});
                    m_esr = 8'h00;
                end
                3'h4: begin
                    rd(GSR_CMD_RD_STB, {8'h00, stb_f()});
                    u_ctl.spoll(d);
                    chk({8'h00, d}, {8'h00, stb_f()});
                end
                3'h5: rd_err();
                3'h6: rd(GSR_CMD_RD_IST, {15'h0000, ist_f()});
                default: begin
                    @(negedge clk);
                    msg_avail = ~msg_avail;
                    @(negedge clk);
                end
            endcase
            if (srq) rd_err();
            sum_chk();
        end
        for (i = 0; i < 8; i++) begin
            if (i[0]) ev(1, 16'h0000);
            r = rnd();
            d = r[7:0];
            wr(GSR_CMD_WR_SRE, d);
            wr(GSR_CMD_WR_PRE, d);
            m_msk[2] = d;
            m_msk[0] = d;
            u_ctl.cfg_pp(i[2:0], i[1]);
            u_ctl.ppoll(oe, lv);
            chk({8'h00, oe}, 16'h0001 << i);
            chk({15'h0000, lv[i]}, {15'h0000, ist_f() ^ i[1]});
        end
        close_out();
    end
endmodule // gsr_status_tb_top
